// file: epv_pkg.sv
/*
 * constants, types and helpers of the encoder position/velocity block.
 * assumes one clock domain and an apb register port.
 */
// What this block does
// - preset touches position one only if enabled
// - scaling off by default: raw position
// - steps and range act on position only when scaling
// - compat with alarm control off: six diagnostic octets
// - compat bit 0 old profile, 1 native
// - compat: ignore request bit of word two, status bit zero
// - native: one life fault tolerated, monitored
// - profile id 31 compat, 41 native
// - version word: two bcd bytes, rest reserved
// - preset runs only on control bit 12
// - preset sets offset, stores about 10 ms
// - preset above range answers code 0x02
// - preset value signed 32, resets to 0
// - preset honoured only with class four
// - life fault limit 1 to 255
// - velocity unit codes 0 to 3
// - velocity only in telegrams 82 to 84
// - velocity recomputed every bus cycle
// - filter weights 7:3, 96:4, 996:4
// - offset shifts the position output
// - rotary axis auto when not integral
// - class four gates scaling, preset, direction
`default_nettype none
package epv_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STEPS = 8'h04;
    localparam logic [7:0] OFS_RANGE = 8'h08;
    localparam logic [7:0] OFS_PRESET = 8'h0c;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h10;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h14;
    localparam logic [7:0] OFS_STAT_ONE = 8'h18;
    localparam logic [7:0] OFS_STAT_TWO = 8'h1c;
    localparam logic [7:0] OFS_POSITION = 8'h20;
    localparam logic [7:0] OFS_VELOCITY = 8'h24;
    localparam logic [7:0] OFS_PROFILE = 8'h28;
    localparam logic [7:0] OFS_RESPONSE = 8'h2c;
    localparam logic [7:0] OFS_OFFSET = 8'h30;
    localparam logic [7:0] OFS_FAULTS = 8'h34;
    // ------------------------------------------------------------
    // config field positions and reset values
    // ------------------------------------------------------------
    localparam int CF_DIR = 0;
    localparam int CF_CLASS4 = 1;
    localparam int CF_PRESET = 2;
    localparam int CF_SCALE = 3;
    localparam int CF_ALARM = 4;
    localparam int CF_COMPAT = 5;
    localparam int CF_UNIT = 8;
    localparam int CF_FILT = 10;
    localparam int CF_TELE = 12;
    localparam int CF_LIMIT = 16;
    localparam logic [31:0] CONFIG_RST = 32'h0001_0020;
    localparam logic [31:0] STEPS_RST = 32'h0000_2000;
    localparam logic [31:0] RANGE_RST = 32'h0200_0000;
    // ------------------------------------------------------------
    // control and status word bits
    // ------------------------------------------------------------
    localparam int CW_PRESET = 12;
    localparam int CW2_REQ = 9;
    localparam int CW2_LIFE = 12;
    localparam int SW_PRESET = 12;
    localparam int SW_ERROR = 15;
    localparam int SW_AXIS = 11;
    localparam int SW2_REQ = 9;
    localparam int SW2_LIFE = 14;
    // ------------------------------------------------------------
    // codes and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RESP_RANGE = 8'h02;
    localparam logic [7:0] PROF_COMPAT = 8'd31;
    localparam logic [7:0] PROF_NATIVE = 8'd41;
    localparam logic [15:0] VER_COMPAT = 16'h0301;
    localparam logic [15:0] VER_NATIVE = 16'h0401;
    localparam logic [7:0] DIAG_SHORT = 8'd6;
    localparam logic [1:0] TELE_NOVEL = 2'd0; // telegram 81
    localparam int AXIS_BASE = 4096;
    localparam int CLK_HZ = 200_000_000;
    localparam int NVM_MS = 10;
    localparam int NVM_CYC = CLK_HZ / 1000 * NVM_MS;
    typedef enum logic [1:0] {
        U_PER_S, U_PER_100MS, U_PER_10MS, U_RPM
    } epv_unit_t;
    typedef enum logic [1:0] {F_FINE, F_NORMAL, F_COARSE} epv_filt_t;
    // old and new weights of the moving average
    function automatic logic [9:0] epv_w_old(input logic [1:0] s);
        case (s)
            2'd1: epv_w_old = 10'd96;
            2'd2: epv_w_old = 10'd996;
            default: epv_w_old = 10'd7;
        endcase
    endfunction : epv_w_old
    function automatic logic [9:0] epv_w_new(input logic [1:0] s);
        epv_w_new = (s == 2'd1 || s == 2'd2) ? 10'd4 : 10'd3;
    endfunction : epv_w_new
endpackage : epv_pkg
`default_nettype wire

// file: epv_filt_if.sv
/*
 * link between the main block and its velocity filter.
 * assumes both ends share clk_in.
 */
`default_nettype none
interface epv_filt_if;
    logic sample; // one cycle per bus cycle
    logic [1:0] sel;
    logic signed [31:0] raw;
    logic signed [31:0] filt;
    modport src (output sample, output sel, output raw, input filt);
    modport flt (input sample, input sel, input raw, output filt);
endinterface : epv_filt_if
`default_nettype wire

// file: epv_filter.sv
/*
 * exponential moving average of the velocity.
 * assumes a sample strobe once per bus cycle.
 */
`default_nettype none
module epv_filter (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // filter link
    epv_filt_if.flt f
);
    import epv_pkg::*;
    logic signed [31:0] filt_q;
    logic signed [63:0] acc;
    logic [10:0] wsum;
    // ------------------------------------------------------------
    // weighted mean of old and new value
    // ------------------------------------------------------------
    always_comb begin
        wsum = {1'b0, epv_w_old(f.sel)} + {1'b0, epv_w_new(f.sel)};
        acc = $signed({54'h0, epv_w_old(f.sel)}) * 64'(filt_q)
            + $signed({54'h0, epv_w_new(f.sel)}) * 64'(f.raw);
    end
    // update once per bus cycle, on the sample strobe
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            filt_q <= 32'sh0;
        end else if (f.sample) begin
            filt_q <= 32'(acc / $signed({53'h0, wsum}));
        end
    end
    assign f.filt = filt_q;
    chk_filter_holds: assert property (@(posedge clk_in)
        disable iff (!arst_n_in) !f.sample |=> $stable(filt_q))
        else $error("filter moved without a sample");
endmodule : epv_filter
`default_nettype wire

// file: epv_core.sv
/*
 * encoder position and velocity processing with apb registers.
 * assumes raw position and bus cycle tick come from logic on clk_in;
 * the life counter arrives in control word two.
 */
`default_nettype none
module epv_core #(
    parameter int NVM_CYCLES = epv_pkg::NVM_CYC,
    parameter int RAW_ST_BITS = 13,
    parameter int BUS_CYCLE_US = 1000
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // encoder side
    input wire logic [31:0] raw_position_in,
    input wire logic bus_cycle_in,
    // cyclic data out
    output logic [31:0] position_value_one_out,
    output logic [31:0] velocity_value_long_out,
    output logic [15:0] velocity_value_short_out,
    output logic [15:0] encoder_status_word_one_out,
    output logic [15:0] encoder_status_word_two_out,
    output logic [7:0] diag_length_out,
    output logic nvm_write_out
);
    import epv_pkg::*;
    // refuse widths and counts the logic cannot serve
    if (RAW_ST_BITS < 1 || RAW_ST_BITS > 31 || BUS_CYCLE_US < 1
        || NVM_CYCLES < 8 || NVM_CYCLES > 8388608) begin : g_param_chk
        $error("epv_core: unsupported parameter values");
    end
    typedef enum logic [1:0] {P_IDLE, P_STORE, P_DONE} epv_pst_t;
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] config_q, steps_q, range_q, ctrl_one_q, ctrl_two_q;
    logic signed [31:0] preset_q, offset_q, pos_q, prev_q;
    logic [7:0] resp_q, faults_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, axis_q, nvm_q, err_q;
    logic [3:0] life_q;
    logic [22:0] nvm_cnt_q;
    epv_pst_t pst_q;
    logic [31:0] vel_long_q;
    logic [15:0] vel_short_q, sw1_q, sw2_q;
    logic [7:0] diag_q;
    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    logic class4, pre_en, scale_en, alarm_en, compat, dir_inv;
    logic [1:0] unit, tele;
    logic [7:0] limit;
    logic ctrl_valid, ctrl_req, wr, setup, mapped;
    assign class4 = config_q[CF_CLASS4];
    assign pre_en = class4 & config_q[CF_PRESET];
    assign scale_en = class4 & config_q[CF_SCALE];
    assign dir_inv = class4 & config_q[CF_DIR];
    assign alarm_en = config_q[CF_ALARM];
    assign compat = ~config_q[CF_COMPAT];
    assign unit = config_q[CF_UNIT+:2];
    assign tele = config_q[CF_TELE+:2];
    // compat uses the set limit, native tolerates one fault
    assign limit = compat ? config_q[CF_LIMIT+:8] : 8'h01;
    // compat ignores the request bit of word two and trusts word one
    assign ctrl_req = ~compat & ctrl_two_q[CW2_REQ];
    assign ctrl_valid = compat | ctrl_two_q[CW2_REQ];
    // ------------------------------------------------------------
    // apb slave: no wait state, answer registered
    // ------------------------------------------------------------
    assign setup = psel_in & ~penable_in;
    assign wr = psel_in & penable_in & pready_q & pwrite_in;
    always_comb begin
        case (paddr_in)
            OFS_CONFIG, OFS_STEPS, OFS_RANGE, OFS_PRESET, OFS_CTRL_ONE,
            OFS_CTRL_TWO, OFS_STAT_ONE, OFS_STAT_TWO, OFS_POSITION,
            OFS_VELOCITY, OFS_PROFILE, OFS_RESPONSE, OFS_OFFSET,
            OFS_FAULTS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // read data and handshake
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                case (paddr_in)
                    OFS_CONFIG: prdata_q <= config_q;
                    OFS_STEPS: prdata_q <= steps_q;
                    OFS_RANGE: prdata_q <= range_q;
                    OFS_PRESET: prdata_q <= preset_q;
                    OFS_CTRL_ONE: prdata_q <= ctrl_one_q;
                    OFS_CTRL_TWO: prdata_q <= ctrl_two_q;
                    OFS_STAT_ONE: prdata_q <= {16'h0, sw1_q};
                    OFS_STAT_TWO: prdata_q <= {16'h0, sw2_q};
                    OFS_POSITION: prdata_q <= pos_q;
                    OFS_VELOCITY: prdata_q <= vel_long_q;
                    OFS_PROFILE: prdata_q <= {8'h0,
                        compat ? PROF_COMPAT : PROF_NATIVE,
                        VER_NATIVE}; // version ignores compat mode
                    OFS_RESPONSE: prdata_q <= {24'h0, resp_q};
                    OFS_OFFSET: prdata_q <= offset_q;
                    OFS_FAULTS: prdata_q <= {24'h0, faults_q};
                    default: prdata_q <= 32'h0;
                endcase
            end
        end
    end
    // writable registers; preset write starts a preset only by clearing a range error with control bit 12 set
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            config_q <= CONFIG_RST;
            steps_q <= STEPS_RST;
            range_q <= RANGE_RST;
            preset_q <= 32'sh0;
            ctrl_one_q <= 32'h0;
            ctrl_two_q <= 32'h0;
            resp_q <= 8'h0;
        end else if (wr) begin
            case (paddr_in)
                OFS_CONFIG: begin
                    config_q <= pwdata_in;
                    if (pwdata_in[CF_LIMIT+:8] == 8'h0) begin
                        config_q[CF_LIMIT+:8] <= 8'h01;
                    end
                end
                OFS_STEPS: steps_q <= pwdata_in;
                OFS_RANGE: range_q <= pwdata_in;
                OFS_PRESET: begin
                    preset_q <= pwdata_in;
                    resp_q <= ($signed(pwdata_in) > 0 &&
                        pwdata_in > range_q) ? RESP_RANGE : 8'h0;
                end
                OFS_CTRL_ONE: ctrl_one_q <= pwdata_in;
                OFS_CTRL_TWO: ctrl_two_q <= pwdata_in;
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // position path: scaling, direction, offset
    // ------------------------------------------------------------
    logic [63:0] scaled;
    logic [31:0] base;
    logic signed [31:0] shifted;
    always_comb begin
        scaled = (64'(raw_position_in) * 64'(steps_q)) >> RAW_ST_BITS;
        if (range_q != 32'h0) begin
            scaled = scaled % 64'(range_q);
        end
        base = scale_en ? scaled[31:0] : raw_position_in;
        if (dir_inv) begin
            base = (scale_en ? range_q : 32'h0) - base;
        end
        shifted = $signed(base) + (pre_en ? offset_q : 32'sh0);
    end
    // rotary axis needed when 4096 x steps / range is fractional
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            axis_q <= 1'b0;
        end else begin
            axis_q <= range_q != 32'h0 && (64'(AXIS_BASE) *
                64'(steps_q)) % 64'(range_q) != 64'h0;
        end
    end
    // ------------------------------------------------------------
    // preset sequence and nonvolatile store
    // ------------------------------------------------------------
    logic go;
    assign go = ctrl_valid & class4 & ctrl_one_q[CW_PRESET]
        & resp_q != RESP_RANGE;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pst_q <= P_IDLE;
            offset_q <= 32'sh0;
            nvm_cnt_q <= 23'h0;
            nvm_q <= 1'b0;
        end else begin
            case (pst_q)
                P_IDLE: if (go) begin
                    offset_q <= preset_q - $signed(base);
                    nvm_cnt_q <= 23'(NVM_CYCLES - 1);
                    nvm_q <= 1'b1;
                    pst_q <= P_STORE;
                end else if (axis_q & ~nvm_q & bus_cycle_in) begin
                    nvm_q <= 1'b0; // axis state not stored; nvm_q already low here
                end
                P_STORE: if (nvm_cnt_q == 23'h0) begin
                    nvm_q <= 1'b0;
                    pst_q <= P_DONE;
                end else begin
                    nvm_cnt_q <= nvm_cnt_q - 23'h1;
                end
                P_DONE: if (~ctrl_one_q[CW_PRESET]) begin
                    pst_q <= P_IDLE;
                end
                default: pst_q <= P_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // sign of life monitoring once per bus cycle
    // ------------------------------------------------------------
    logic [3:0] life_in;
    assign life_in = ctrl_two_q[CW2_LIFE+:4];
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            life_q <= 4'h0;
            faults_q <= 8'h0;
            err_q <= 1'b0;
        end else if (bus_cycle_in) begin
            life_q <= life_in;
            if (life_in != life_q + 4'h1) begin
                if (faults_q != 8'hff) begin
                    faults_q <= faults_q + 8'h1;
                end
                if (faults_q >= limit) begin
                    err_q <= 1'b1;
                end
            end else begin
                faults_q <= 8'h0;
            end
        end
    end
    // ------------------------------------------------------------
    // velocity: raw difference per cycle, units, filter
    // ------------------------------------------------------------
    epv_filt_if fl ();
    logic signed [63:0] diff, vraw;
    always_comb begin
        diff = 64'(shifted) - 64'(prev_q);
        case (unit)
            U_PER_S: vraw = diff * 64'sd1_000_000 / BUS_CYCLE_US;
            U_PER_100MS: vraw = diff * 64'sd100_000 / BUS_CYCLE_US;
            U_PER_10MS: vraw = diff * 64'sd10_000 / BUS_CYCLE_US;
            default: vraw = (steps_q == 32'h0) ? 64'sh0 : diff
                * 64'sd60_000_000 / BUS_CYCLE_US
                / $signed({32'h0, steps_q});
        endcase
    end
    assign fl.sample = bus_cycle_in;
    assign fl.sel = config_q[CF_FILT+:2];
    assign fl.raw = 32'(vraw);
    epv_filter u_filter (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .f(fl)
    );
    // cyclic outputs, refreshed every bus cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_q <= 32'sh0;
            pos_q <= 32'sh0;
            vel_long_q <= 32'h0;
            vel_short_q <= 16'h0;
        end else if (bus_cycle_in) begin
            prev_q <= shifted;
            pos_q <= shifted;
            vel_long_q <= (tele == TELE_NOVEL) ? 32'h0 : fl.filt;
            vel_short_q <= (tele == TELE_NOVEL) ? 16'h0 : fl.filt[15:0];
        end
    end
    // status words and diagnostic length
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sw1_q <= 16'h0;
            sw2_q <= 16'h0;
            diag_q <= DIAG_SHORT;
        end else begin
            sw1_q <= 16'h0;
            sw1_q[SW_PRESET] <= pst_q == P_DONE;
            sw1_q[SW_ERROR] <= err_q;
            sw1_q[SW_AXIS] <= axis_q;
            sw2_q <= 16'h0;
            sw2_q[SW2_REQ] <= ctrl_req;
            sw2_q[SW2_LIFE] <= err_q;
            diag_q <= (compat & ~alarm_en) ? DIAG_SHORT : 8'hff;
        end
    end
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign position_value_one_out = pos_q;
    assign velocity_value_long_out = vel_long_q;
    assign velocity_value_short_out = vel_short_q;
    assign encoder_status_word_one_out = sw1_q;
    assign encoder_status_word_two_out = sw2_q;
    assign diag_length_out = diag_q;
    assign nvm_write_out = nvm_q;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    chk_raw_when_unscaled: assert property (
        bus_cycle_in && !scale_en && !pre_en && !dir_inv
        |=> pos_q == $past(raw_position_in))
        else $error("position not raw with scaling off");
    chk_compat_req_zero: assert property (compat |=> !sw2_q[SW2_REQ])
        else $error("control request set in compat mode");
    chk_profile_id: assert property (
        setup && paddr_in == OFS_PROFILE
        |=> prdata_q[23:16] == (compat ? 8'd31 : 8'd41)
        && prdata_q[15:0] == VER_NATIVE)
        else $error("wrong profile id");
    chk_preset_needs_bit: assert property (
        pst_q == P_IDLE && !ctrl_one_q[CW_PRESET] |=> pst_q == P_IDLE)
        else $error("preset without control bit");
    chk_preset_class4: assert property (
        pst_q == P_IDLE && !class4 |=> !nvm_q)
        else $error("preset without class four");
    chk_preset_range: assert property (
        wr && paddr_in == OFS_PRESET && $signed(pwdata_in) > 0
        && pwdata_in > range_q |=> resp_q == 8'h02)
        else $error("range error not reported");
    chk_diag_short: assert property (
        compat && !alarm_en |=> diag_q == 8'd6)
        else $error("diagnostic length not six");
    chk_velo_none_81: assert property (
        bus_cycle_in && tele == 2'd0
        |=> vel_long_q == 32'h0 && vel_short_q == 16'h0)
        else $error("velocity in telegram 81");
    chk_store_time: assert property ($rose(nvm_q) |-> nvm_q[*8])
        else $error("store ended too early");
    chk_apb_ready: assert property (setup |=> pready_q)
        else $error("apb answer late");
    cov_preset_done: cover property (pst_q == P_STORE ##1 pst_q == P_DONE);
    cov_range_error: cover property (resp_q == 8'h02);
    cov_axis_on: cover property ($rose(axis_q));
    cov_life_error: cover property ($rose(err_q));
endmodule : epv_core
`default_nettype wire

// file: epv_plc_model.sv
/* far-side model: bus cycle pulses and a moving raw position.
   assumes the block's clock and its active-low reset. */
`default_nettype none
module epv_plc_model #(
    parameter int PERIOD = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // motion and cyclic outputs
    input wire logic [31:0] step_in,
    output logic bus_cycle_out,
    output logic [31:0] raw_position_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    // pulse once per bus cycle; shaft idles while step_in is 0
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 0;
            bus_cycle_out <= 1'b0;
            raw_position_out <= 32'h0000_1234;
        end else begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            bus_cycle_out <= (cnt_q == PERIOD - 1);
            if (cnt_q == PERIOD - 1) begin
                raw_position_out <= raw_position_out + step_in;
            end
        end
    end
endmodule : epv_plc_model
`default_nettype wire

// file: encoder_position_velocity_config_tb.sv
/* bench of the encoder position/velocity block.
   assumes epv_pkg, epv_core, epv_filter and epv_plc_model. */
`default_nettype none
module encoder_position_velocity_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import epv_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, se, bc, nvm;
    logic [7:0] pa = 8'h00, diag;
    logic [31:0] pwd = 32'h0, step = 32'h0, prd, raw, pos, vl, rd;
    logic [15:0] vs, sw1, sw2;
    int n_fail = 0, n_compared = 0, cyc = 0, k;
    // clock and hang guard
    initial forever #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    epv_core #(.NVM_CYCLES(16)) u_dut (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(err), .raw_position_in(raw),
        .bus_cycle_in(bc), .position_value_one_out(pos),
        .velocity_value_long_out(vl), .velocity_value_short_out(vs),
        .encoder_status_word_one_out(sw1),
        .encoder_status_word_two_out(sw2), .diag_length_out(diag),
        .nvm_write_out(nvm));
    epv_plc_model u_plc (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .step_in(step), .bus_cycle_out(bc), .raw_position_out(raw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        // pready sampled at the rising edge, data taken at that edge
        do @(posedge clk_in); while (rdy !== 1'b1);
        rd = prd;
        se = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // reset values, profile word, unmapped address
    task automatic t_reset;
        apb(1'b0, OFS_CONFIG, 32'h0);
        chk(rd, CONFIG_RST);
        apb(1'b0, OFS_PRESET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_PROFILE, 32'h0);
        chk(32'(rd[23:16]), 32'(PROF_NATIVE));
        chk({rd[31:24], 8'h00, rd[15:0]}, 32'(VER_NATIVE));
        apb(1'b0, 8'hfc, 32'h0);
        chk({rd[30:0], se}, 32'h1);
    endtask : t_reset
    // raw output unless class four and scaling both set
    task automatic t_scale;
        apb(1'b1, OFS_STEPS, 32'h1000);
        apb(1'b1, OFS_CONFIG, CONFIG_RST | 32'h8);
        repeat (20) @(posedge clk_in);
        chk(pos, raw);
        apb(1'b1, OFS_CONFIG, CONFIG_RST | 32'ha);
        repeat (20) @(posedge clk_in);
        chk(pos, raw >> 1);
        chk(32'(sw1[11]), 32'h1);
        apb(1'b1, OFS_STEPS, STEPS_RST);
        repeat (3) @(posedge clk_in);
        chk(32'(sw1[11]), 32'h0);
    endtask : t_scale
    // no velocity in telegram 81, present in 82
    task automatic t_vel;
        step <= 32'h10;
        apb(1'b1, OFS_CONFIG, CONFIG_RST);
        repeat (40) @(posedge clk_in);
        chk(vl, 32'h0);
        apb(1'b1, OFS_CONFIG, CONFIG_RST | 32'h1000);
        // 16 steps per 1000 us cycle settle near 16000 steps per second
        repeat (300) @(posedge clk_in);
        chk(32'(vl >= 32'd15990 && vl <= 32'd16010), 32'h1);
        chk(32'(vs), {16'h0, vl[15:0]});
        step <= 32'h0;
        repeat (80) @(posedge clk_in);
    endtask : t_vel
    // preset needs control bit 12, stores, shifts position
    task automatic t_preset;
        apb(1'b1, OFS_CONFIG, CONFIG_RST | 32'h6);
        apb(1'b1, OFS_PRESET, 32'h100);
        apb(1'b1, OFS_CTRL_TWO, 32'h200);
        repeat (30) @(posedge clk_in);
        chk(32'(nvm), 32'h0);
        apb(1'b1, OFS_CTRL_ONE, 32'h1000);
        for (k = 0; nvm !== 1'b1 && k < 200; k++) @(negedge clk_in);
        for (k = 0; nvm === 1'b1; k++) @(negedge clk_in);
        chk(32'(k), 32'd16);
        for (k = 0; sw1[12] !== 1'b1 && k < 5; k++) @(negedge clk_in);
        chk(32'(sw1[12]), 32'h1);
        repeat (20) @(posedge clk_in);
        chk(pos, 32'h100);
        apb(1'b1, OFS_CTRL_ONE, 32'h0);
        apb(1'b1, OFS_PRESET, 32'h0300_0000);
        apb(1'b0, OFS_RESPONSE, 32'h0);
        chk(32'(rd[7:0]), 32'(RESP_RANGE));
    endtask : t_preset
    // compatibility operation against native
    task automatic t_compat;
        apb(1'b1, OFS_CONFIG, CONFIG_RST & ~32'h20);
        apb(1'b1, OFS_CTRL_TWO, 32'h200);
        repeat (30) @(posedge clk_in);
        chk(32'(sw2[9]), 32'h0);
        chk(32'(diag), 32'(DIAG_SHORT));
        apb(1'b0, OFS_PROFILE, 32'h0);
        chk({8'h0, rd[23:0]}, {8'h0, PROF_COMPAT, VER_NATIVE});
        chk(32'(sw2[14]), 32'h1);
        apb(1'b1, OFS_CONFIG, CONFIG_RST);
        repeat (30) @(posedge clk_in);
        chk(32'(sw2[9]), 32'h1);
    endtask : t_compat
    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        chk(32'(diag), 32'(DIAG_SHORT));
        arst_n_in <= 1'b1;
        t_reset();
        t_scale();
        t_vel();
        t_preset();
        t_compat();
        tally_and_finish();
    end
endmodule : encoder_position_velocity_config_tb
`default_nettype wire
